// >>> ppc_regs.svh
// Address map, field positions, masks and reset values of the port pin control block.
// Operation
// - Output mode drives latch level on pin; input mode reads pin level.
// - Pull-up connects only when its select bit is set and pin is input.
// - Pull-up stays off for any pin in output mode.
// - Pull-up selects reset to zero; port 12 resets with bit 3 set.
// - Pull-up select 0 disconnects; 1 requests connection in input mode.
// - Drive type 0 push-pull, 1 N-channel open drain, port 0 bit 7 P-channel; port 0 latch keeps bits 0-1 only, so that P-channel never drives.
// - Reset-pin mode bit 3 clear keeps reset function; set frees other functions.
// - Output mode write stores latch, drives pin, latch holds until next write; port 0 latch stores bits 0-1 only.
// - Input mode write updates latch while the pin stays undriven; port 0 latch updates bits 0-1 only.
// - Chip reset clears every output latch.
// - Output mode read returns latch contents, latch unchanged.
// - Input mode read returns pin levels, latch unchanged; port 0 bits 2-7 read as zero.
// - Output mode operation uses latch operand and writes result to latch.
// - Latch, pull-up, drive type and reset-pin mode accept bit and byte writes.
// - Direction 0 output with buffer on, 1 input; direction resets to all ones.
// - Input mode operation uses pin levels, writes result to latch.
`ifndef PPC_REGS_SVH
`define PPC_REGS_SVH

`define PPC_NUM_PORTS 5

`define PPC_ADDR_LATCH0 16'hff00
`define PPC_ADDR_LATCH1 16'hff01
`define PPC_ADDR_LATCH2 16'hff02
`define PPC_ADDR_LATCH3 16'hff03
`define PPC_ADDR_LATCH12 16'hff0c
`define PPC_ADDR_DIR0 16'hff20
`define PPC_ADDR_DIR1 16'hff21
`define PPC_ADDR_DIR2 16'hff22
`define PPC_ADDR_DIR3 16'hff23
`define PPC_ADDR_DIR12 16'hff2c
`define PPC_ADDR_RESET_PIN_MODE 16'hff2e
`define PPC_ADDR_PU0 16'hff30
`define PPC_ADDR_PU1 16'hff31
`define PPC_ADDR_PU2 16'hff32
`define PPC_ADDR_PU3 16'hff33
`define PPC_ADDR_PORT12_PULLUP_SELECT 16'hff3c
`define PPC_ADDR_PORT0_DRIVE_TYPE 16'hff38
`define PPC_ADDR_PORT1_DRIVE_TYPE 16'hff39
`define PPC_ADDR_PORT2_DRIVE_TYPE 16'hff3a
`define PPC_ADDR_PORT3_DRIVE_TYPE 16'hff3b
`define PPC_ADDR_PORT12_DRIVE_TYPE 16'hff3e

`define PPC_LATCH_MASK0 8'h03
`define PPC_LATCH_MASK1 8'hff
`define PPC_LATCH_MASK2 8'hff
`define PPC_LATCH_MASK3 8'h3f
`define PPC_LATCH_MASK12 8'h0f
`define PPC_DIR_MASK0 8'hff
`define PPC_DIR_MASK1 8'hff
`define PPC_DIR_MASK2 8'hff
`define PPC_DIR_MASK3 8'h3f
`define PPC_DIR_MASK12 8'h07
`define PPC_PU_MASK0 8'hff
`define PPC_PU_MASK1 8'hff
`define PPC_PU_MASK2 8'hff
`define PPC_PU_MASK3 8'h3f
`define PPC_PU_MASK12 8'h09
`define PPC_POM_MASK0 8'hff
`define PPC_POM_MASK1 8'hff
`define PPC_POM_MASK2 8'hff
`define PPC_POM_MASK3 8'h3f
`define PPC_POM_MASK12 8'h07
`define PPC_PCH_MASK0 8'h80
`define PPC_RSTMODE_MASK 8'h08

`define PPC_LATCH_RESET 8'h00
`define PPC_DIR_RESET 8'hff
`define PPC_PU_RESET 8'h00
`define PPC_PORT12_PULLUP_SELECT_RESET 8'h08
`define PPC_POM_RESET 8'h00
`define PPC_RSTMODE_RESET 8'h00

`define PPC_RESET_PIN_ALT_ENABLE_BIT 3
`define PPC_PORT12_IDX 4
`define PPC_RESET_PIN_BIT 3
`define PPC_IDLE_READ 8'h00

`endif

// >>> ppc_pkg.sv
// Types shared by the port pin control modules.
package ppc_pkg;
  typedef logic [7:0] ppc_byte_t;
  typedef enum {
    PPC_REG_NONE,
    PPC_REG_LATCH,
    PPC_REG_DIR,
    PPC_REG_PULLUP,
    PPC_REG_DRIVE,
    PPC_REG_RSTMODE
  } ppc_reg_kind_t;
endpackage

// >>> ppc_port_if.sv
// Register strobes and state between the decoder and one port's storage.
`timescale 1ns/10ps
interface ppc_port_if;
  import ppc_pkg::*;
  logic wr_latch;
  logic wr_dir;
  logic wr_pu;
  logic wr_pom;
  ppc_byte_t wdata;
  ppc_byte_t latch;
  ppc_byte_t dir;
  ppc_byte_t pu;
  ppc_byte_t pom;
  ppc_byte_t pin;
  modport ctrl (
    output wr_latch, wr_dir, wr_pu, wr_pom, wdata,
    input latch, dir, pu, pom, pin
  );
  modport port (
    input wr_latch, wr_dir, wr_pu, wr_pom, wdata,
    output latch, dir, pu, pom, pin
  );
endinterface

// >>> ppc_port.sv
// Storage and pin synchroniser for one eight-bit port.
`timescale 1ns/10ps
`include "ppc_regs.svh"
module ppc_port
  import ppc_pkg::*;
#(
  parameter ppc_byte_t LATCH_MASK = 8'hff,
  parameter ppc_byte_t DIR_MASK = 8'hff,
  parameter ppc_byte_t PU_MASK = 8'hff,
  parameter ppc_byte_t POM_MASK = 8'hff,
  parameter ppc_byte_t PU_RESET = 8'h00
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Raw pin levels.
  input wire logic [7:0] pin_in,
  // Register side.
  ppc_port_if.port bus
);
  ppc_byte_t latch_q;
  ppc_byte_t dir_q;
  ppc_byte_t pu_q;
  ppc_byte_t pom_q;
  ppc_byte_t pin_s1_q;
  ppc_byte_t pin_s2_q;

  // Latch holds until the next write in either mode and clears on reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_q <= `PPC_LATCH_RESET;
    end else if (bus.wr_latch) begin
      latch_q <= bus.wdata & LATCH_MASK;
    end
  end

  // Unimplemented direction bits stay fixed at one.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_q <= `PPC_DIR_RESET;
    end else if (bus.wr_dir) begin
      dir_q <= bus.wdata | ~DIR_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pu_q <= PU_RESET;
    end else if (bus.wr_pu) begin
      pu_q <= bus.wdata & PU_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pom_q <= `PPC_POM_RESET;
    end else if (bus.wr_pom) begin
      pom_q <= bus.wdata & POM_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 8'h00;
      pin_s2_q <= 8'h00;
    end else begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  assign bus.latch = latch_q;
  assign bus.dir = dir_q;
  assign bus.pu = pu_q;
  assign bus.pom = pom_q;
  assign bus.pin = pin_s2_q;
endmodule

// >>> ppc_port_pin_control.sv
// Port pin control: register decode, read view, bit writes and pad drive.
`timescale 1ns/10ps
`include "ppc_regs.svh"
module ppc_port_pin_control
  import ppc_pkg::*;
(
  // Clock and reset.
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // Processor memory access.
  input wire logic [15:0] ADDR,
  input wire logic WR_EN,
  input wire logic WR_BIT,
  input wire logic [2:0] BIT_SEL,
  input wire logic [7:0] WDATA,
  input wire logic RD_EN,
  output logic [7:0] RDATA,
  // Pins, eight per port in order 0, 1, 2, 3, 12.
  input wire logic [39:0] PIN_IN,
  output logic [39:0] PIN_OUT,
  output logic [39:0] PIN_OE,
  output logic [39:0] PIN_PULLUP,
  // Shared reset pin functions.
  output logic RESET_PIN_AS_RESET,
  output logic KEY_RETURN_INPUT_8,
  output logic EXT_IRQ_INPUT_5
);
  localparam int NP = `PPC_NUM_PORTS;
  localparam logic [15:0] LATCH_ADDR [NP] = '{`PPC_ADDR_LATCH0, `PPC_ADDR_LATCH1,
    `PPC_ADDR_LATCH2, `PPC_ADDR_LATCH3, `PPC_ADDR_LATCH12};
  localparam logic [15:0] DIR_ADDR [NP] = '{`PPC_ADDR_DIR0, `PPC_ADDR_DIR1,
    `PPC_ADDR_DIR2, `PPC_ADDR_DIR3, `PPC_ADDR_DIR12};
  localparam logic [15:0] PU_ADDR [NP] = '{`PPC_ADDR_PU0, `PPC_ADDR_PU1,
    `PPC_ADDR_PU2, `PPC_ADDR_PU3, `PPC_ADDR_PORT12_PULLUP_SELECT};
  localparam logic [15:0] POM_ADDR [NP] = '{`PPC_ADDR_PORT0_DRIVE_TYPE, `PPC_ADDR_PORT1_DRIVE_TYPE,
    `PPC_ADDR_PORT2_DRIVE_TYPE, `PPC_ADDR_PORT3_DRIVE_TYPE, `PPC_ADDR_PORT12_DRIVE_TYPE};
  localparam ppc_byte_t LATCH_MASK [NP] = '{`PPC_LATCH_MASK0, `PPC_LATCH_MASK1,
    `PPC_LATCH_MASK2, `PPC_LATCH_MASK3, `PPC_LATCH_MASK12};
  localparam ppc_byte_t DIR_MASK [NP] = '{`PPC_DIR_MASK0, `PPC_DIR_MASK1,
    `PPC_DIR_MASK2, `PPC_DIR_MASK3, `PPC_DIR_MASK12};
  localparam ppc_byte_t PU_MASK [NP] = '{`PPC_PU_MASK0, `PPC_PU_MASK1,
    `PPC_PU_MASK2, `PPC_PU_MASK3, `PPC_PU_MASK12};
  localparam ppc_byte_t POM_MASK [NP] = '{`PPC_POM_MASK0, `PPC_POM_MASK1,
    `PPC_POM_MASK2, `PPC_POM_MASK3, `PPC_POM_MASK12};
  localparam ppc_byte_t PU_RESET [NP] = '{`PPC_PU_RESET, `PPC_PU_RESET,
    `PPC_PU_RESET, `PPC_PU_RESET, `PPC_PORT12_PULLUP_SELECT_RESET};
  localparam ppc_byte_t PCH_MASK [NP] = '{`PPC_PCH_MASK0, 8'h00, 8'h00, 8'h00, 8'h00};

  //////////////////////////////////////////////////////////////////////////////
  // Reset release.

  logic rst_s1_q;
  logic rst_n;

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Port storage.

  ppc_port_if pif [NP] ();
  ppc_byte_t latch_v [NP];
  ppc_byte_t dir_v [NP];
  ppc_byte_t pu_v [NP];
  ppc_byte_t pom_v [NP];
  ppc_byte_t pin_v [NP];
  ppc_byte_t view_v [NP];
  logic [NP-1:0] sel_latch;
  logic [NP-1:0] sel_dir;
  logic [NP-1:0] sel_pu;
  logic [NP-1:0] sel_pom;
  logic sel_rstmode;
  ppc_byte_t wbyte;
  ppc_byte_t rstmode_q;

  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_port
      ppc_port #(
        .LATCH_MASK(LATCH_MASK[gp]),
        .DIR_MASK(DIR_MASK[gp]),
        .PU_MASK(PU_MASK[gp]),
        .POM_MASK(POM_MASK[gp]),
        .PU_RESET(PU_RESET[gp])
      ) u_port (
        .clk(CLK_SYS),
        .rst_n(rst_n),
        .pin_in(PIN_IN[gp*8 +: 8]),
        .bus(pif[gp].port)
      );
      assign pif[gp].wr_latch = WR_EN & sel_latch[gp];
      assign pif[gp].wr_dir = WR_EN & sel_dir[gp];
      assign pif[gp].wr_pu = WR_EN & sel_pu[gp];
      assign pif[gp].wr_pom = WR_EN & sel_pom[gp];
      assign pif[gp].wdata = wbyte;
      assign latch_v[gp] = pif[gp].latch;
      assign dir_v[gp] = pif[gp].dir;
      assign pu_v[gp] = pif[gp].pu;
      assign pom_v[gp] = pif[gp].pom;
      assign pin_v[gp] = pif[gp].pin;
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Read view of each port register.

  // Output bits show the latch, input bits the synchronised pin level.
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      view_v[p] = ((latch_v[p] & ~dir_v[p]) | (pin_v[p] & dir_v[p]))
        & LATCH_MASK[p];
    end
    // While the shared pin serves as reset its port bit reads as zero.
    view_v[`PPC_PORT12_IDX][`PPC_RESET_PIN_BIT] = pin_v[`PPC_PORT12_IDX][`PPC_RESET_PIN_BIT]
      & rstmode_q[`PPC_RESET_PIN_ALT_ENABLE_BIT];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Address decode.

  always_comb begin
    sel_latch = '0;
    sel_dir = '0;
    sel_pu = '0;
    sel_pom = '0;
    for (int p = 0; p < NP; p++) begin
      sel_latch[p] = (ADDR == LATCH_ADDR[p]);
      sel_dir[p] = (ADDR == DIR_ADDR[p]);
      sel_pu[p] = (ADDR == PU_ADDR[p]);
      sel_pom[p] = (ADDR == POM_ADDR[p]);
    end
  end

  assign sel_rstmode = (ADDR == `PPC_ADDR_RESET_PIN_MODE);

  // The value a read of the addressed register returns right now.
  ppc_byte_t cur_read;

  always_comb begin
    cur_read = `PPC_IDLE_READ;
    for (int p = 0; p < NP; p++) begin
      if (sel_latch[p]) begin
        cur_read = view_v[p];
      end
      if (sel_dir[p]) begin
        cur_read = dir_v[p];
      end
      if (sel_pu[p]) begin
        cur_read = pu_v[p];
      end
      if (sel_pom[p]) begin
        cur_read = pom_v[p];
      end
    end
    if (sel_rstmode) begin
      cur_read = rstmode_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write data.

  // A bit write reads the whole byte, replaces one bit and writes the byte back.
  // On a port this takes pin levels for input bits and latch bits for output
  // bits, so input-bit latches pick up the pin level.
  always_comb begin
    wbyte = WDATA;
    if (WR_BIT) begin
      wbyte = cur_read;
      wbyte[BIT_SEL] = WDATA[0];
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      rstmode_q <= `PPC_RSTMODE_RESET;
    end else if (WR_EN && sel_rstmode) begin
      rstmode_q <= wbyte & `PPC_RSTMODE_MASK;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data.

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      RDATA <= `PPC_IDLE_READ;
    end else if (RD_EN) begin
      RDATA <= cur_read;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pad drive.

  logic [39:0] out_d;
  logic [39:0] oe_d;
  logic [39:0] pull_d;

  always_comb begin
    for (int p = 0; p < NP; p++) begin
      for (int b = 0; b < 8; b++) begin
        if (!LATCH_MASK[p][b] && !POM_MASK[p][b]) begin
          out_d[p*8+b] = 1'b0;
          oe_d[p*8+b] = 1'b0;
        end else if (!pom_v[p][b]) begin
          out_d[p*8+b] = latch_v[p][b];
          oe_d[p*8+b] = ~dir_v[p][b];
        end else if (PCH_MASK[p][b]) begin
          out_d[p*8+b] = 1'b1;
          oe_d[p*8+b] = ~dir_v[p][b] & latch_v[p][b];
        end else begin
          out_d[p*8+b] = 1'b0;
          oe_d[p*8+b] = ~dir_v[p][b] & ~latch_v[p][b];
        end
        pull_d[p*8+b] = pu_v[p][b] & dir_v[p][b];
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      PIN_OUT <= '0;
      PIN_OE <= '0;
      PIN_PULLUP <= '0;
    end else begin
      PIN_OUT <= out_d;
      PIN_OE <= oe_d;
      PIN_PULLUP <= pull_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shared reset pin.

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      RESET_PIN_AS_RESET <= 1'b1;
      KEY_RETURN_INPUT_8 <= 1'b0;
      EXT_IRQ_INPUT_5 <= 1'b0;
    end else begin
      RESET_PIN_AS_RESET <= ~rstmode_q[`PPC_RESET_PIN_ALT_ENABLE_BIT];
      KEY_RETURN_INPUT_8 <= pin_v[`PPC_PORT12_IDX][`PPC_RESET_PIN_BIT]
        & rstmode_q[`PPC_RESET_PIN_ALT_ENABLE_BIT];
      EXT_IRQ_INPUT_5 <= pin_v[`PPC_PORT12_IDX][`PPC_RESET_PIN_BIT]
        & rstmode_q[`PPC_RESET_PIN_ALT_ENABLE_BIT];
    end
  end
endmodule

// >>> ppc_port_pin_control_chk.sv
// Concurrent checks on the top ports of the port pin control block.
`timescale 1ns/10ps
module ppc_port_pin_control_chk (
  // Clock and reset.
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // Processor access.
  input wire logic [15:0] ADDR,
  input wire logic WR_EN,
  input wire logic WR_BIT,
  input wire logic [7:0] WDATA,
  input wire logic RD_EN,
  input wire logic [7:0] RDATA,
  // Pads.
  input wire logic [39:0] PIN_OUT,
  input wire logic [39:0] PIN_OE,
  input wire logic [39:0] PIN_PULLUP,
  input wire logic RESET_PIN_AS_RESET,
  input wire logic KEY_RETURN_INPUT_8,
  input wire logic EXT_IRQ_INPUT_5
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_B);
  ////////////////////////////////////////////////////////////
  property p_rst_quiet;
    $rose(RST_B) |-> (PIN_OE == 40'h0 && RESET_PIN_AS_RESET) [*2];
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("pads active after reset");
  property p_rst_pu;
    $rose(RST_B) |-> ##3 PIN_PULLUP == 40'h0800000000;
  endproperty
  a_rst_pu: assert property (p_rst_pu) else $error("wrong pull-ups after reset");
  property p_unmapped;
    RD_EN && ADDR == 16'hff10 |=> RDATA == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_dir_fixed;
    RD_EN && ADDR == 16'hff2c |=> RDATA[7:3] == 5'h1f;
  endproperty
  a_dir_fixed: assert property (p_dir_fixed) else $error("fixed direction bits wrong");
  property p_rstmode;
    logic v;
    (WR_EN && !WR_BIT && ADDR == 16'hff2e, v = WDATA[3]) |-> ##2 RESET_PIN_AS_RESET == !v;
  endproperty
  a_rstmode: assert property (p_rstmode) else $error("reset pin mode not applied");
  property p_alt_off;
    RESET_PIN_AS_RESET |-> !KEY_RETURN_INPUT_8 && !EXT_IRQ_INPUT_5;
  endproperty
  a_alt_off: assert property (p_alt_off) else $error("alternate input while reset pin");
  property p_pu_not_out;
    (PIN_OE & PIN_PULLUP) == 40'h0;
  endproperty
  a_pu_not_out: assert property (p_pu_not_out) else $error("pull-up on driven pin");
  property p_latch_out;
    logic [7:0] v;
    (WR_EN && !WR_BIT && ADDR == 16'hff01, v = WDATA) |->
      ##2 (PIN_OUT[15:8] & PIN_OE[15:8]) == (v & PIN_OE[15:8]);
  endproperty
  a_latch_out: assert property (p_latch_out) else $error("latch not on pins");
  property p_rdata_hold;
    !RD_EN |=> $stable(RDATA);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  c_bit_write: cover property (WR_EN && WR_BIT);
  c_alt_on: cover property (!RESET_PIN_AS_RESET);
  c_pull: cover property (PIN_PULLUP[15:8] != 8'h00);
endmodule
bind ppc_port_pin_control ppc_port_pin_control_chk u_chk (.CLK_SYS(CLK_SYS), .RST_B(RST_B),
  .ADDR(ADDR), .WR_EN(WR_EN), .WR_BIT(WR_BIT), .WDATA(WDATA), .RD_EN(RD_EN), .RDATA(RDATA),
  .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .PIN_PULLUP(PIN_PULLUP),
  .RESET_PIN_AS_RESET(RESET_PIN_AS_RESET), .KEY_RETURN_INPUT_8(KEY_RETURN_INPUT_8),
  .EXT_IRQ_INPUT_5(EXT_IRQ_INPUT_5));

// >>> ppc_pin_board.sv
// Board side of the pins: external drivers, pull-ups and floating lines.
`timescale 1ns/10ps
module ppc_pin_board (
  // Clock for the floating pattern.
  input wire logic clk,
  // Device pad controls.
  input wire logic [39:0] pin_out,
  input wire logic [39:0] pin_oe,
  input wire logic [39:0] pin_pullup,
  // External drive.
  input wire logic [39:0] ext_val,
  input wire logic [39:0] ext_en,
  // Resolved levels.
  output logic [39:0] pin_lvl
);
  logic [39:0] float_q = 40'h0;
  ////////////////////////////////////////////////////////////
  // An undriven line without pull-up must not settle to a tidy value.
  always @(posedge clk) begin
    float_q <= ~float_q;
  end
  always_comb begin
    for (int i = 0; i < 40; i++) begin
      if (pin_oe[i]) begin
        pin_lvl[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_lvl[i] = ext_val[i];
      end else if (pin_pullup[i]) begin
        pin_lvl[i] = 1'b1;
      end else begin
        pin_lvl[i] = float_q[i];
      end
    end
  end
endmodule

// >>> ppc_port_pin_control_bench.sv
// Self-checking bench for the port pin control block.
`timescale 1ns/10ps
`define CHK(g, e) chk_val(40'(g), 40'(e))
module ppc_port_pin_control_bench;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] addr = 16'h0;
  logic wr_en = 1'b0;
  logic wr_bit = 1'b0;
  logic [2:0] bit_sel = 3'h0;
  logic [7:0] wdata = 8'h0;
  logic rd_en = 1'b0;
  logic [7:0] rdata;
  logic [39:0] pin_in, pin_out, pin_oe, pin_pu;
  logic rst_as_rst, key8, irq5;
  logic [39:0] ext_val = 40'h0;
  logic [39:0] ext_en = {40{1'b1}};
  int bad_count = 0;
  int n_checks = 0;
  int m[5][4];
  int rsm;
  int offs[5] = '{0, 1, 2, 3, 12};
  int mk[4][5] = '{'{8'h03, 8'hff, 8'hff, 8'h3f, 8'h0f}, '{8'hff, 8'hff, 8'hff, 8'h3f, 8'h07},
    '{8'hff, 8'hff, 8'hff, 8'h3f, 8'h09}, '{8'hff, 8'hff, 8'hff, 8'h3f, 8'h07}};
  ppc_port_pin_control dut (.CLK_SYS(clk_sys), .RST_B(rst_b), .ADDR(addr), .WR_EN(wr_en),
    .WR_BIT(wr_bit), .BIT_SEL(bit_sel), .WDATA(wdata), .RD_EN(rd_en), .RDATA(rdata),
    .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PIN_PULLUP(pin_pu),
    .RESET_PIN_AS_RESET(rst_as_rst), .KEY_RETURN_INPUT_8(key8), .EXT_IRQ_INPUT_5(irq5));
  ppc_pin_board board (.clk(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pu),
    .ext_val(ext_val), .ext_en(ext_en), .pin_lvl(pin_in));
  ////////////////////////////////////////////////////////////
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic chk_val(input logic [39:0] g, input logic [39:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  function automatic int lvl(int p);
    return int'(ext_val[p*8 +: 8] | ~ext_en[p*8 +: 8]);
  endfunction
  // Register kinds: 0 latch, 1 direction, 2 pull-up, 3 drive type, 4 reset pin, 5 unmapped.
  function automatic logic [15:0] adr(int k, int p);
    case (k)
      0: return 16'hff00 + 16'(offs[p]);
      1: return 16'hff20 + 16'(offs[p]);
      2: return 16'hff30 + 16'(offs[p]);
      3: return p == 4 ? 16'hff3e : 16'hff38 + 16'(offs[p]);
      4: return 16'hff2e;
      default: return 16'hff10;
    endcase
  endfunction
  function automatic int view(int k, int p);
    int d;
    int v;
    d = (m[p][1] | ~mk[1][p]) & 255;
    case (k)
      0: begin
        v = ((d & lvl(p)) | (~d & m[p][0])) & mk[0][p];
        if (p == 4 && rsm == 0) v &= 32'hf7;
      end
      1: v = d;
      4: v = rsm;
      5: v = 0;
      default: v = m[p][k];
    endcase
    return v;
  endfunction
  task automatic wr(int k, int p, int v, bit bw = 1'b0, int b = 0);
    int cur;
    cur = view(k, p);
    @(posedge clk_sys);
    addr <= adr(k, p);
    wr_en <= 1'b1;
    wr_bit <= bw;
    bit_sel <= 3'(b);
    wdata <= 8'(v);
    @(posedge clk_sys);
    wr_en <= 1'b0;
    if (bw) v = (cur & ~(1 << b)) | ((v & 1) << b);
    if (k == 4) rsm = v & 8;
    else if (k < 4) m[p][k] = v & mk[k][p];
  endtask
  task automatic rd(int k, int p);
    int e;
    @(posedge clk_sys);
    addr <= adr(k, p);
    rd_en <= 1'b1;
    e = view(k, p);
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    `CHK(rdata, e);
  endtask
  task automatic pins_chk();
    int d, l, o, c;
    logic [39:0] eoe, eou, epu;
    repeat (2) @(posedge clk_sys);
    #1;
    for (int p = 0; p < 5; p++) begin
      d = view(1, p);
      l = m[p][0];
      o = m[p][3];
      c = p == 0 ? 8'h80 : 0;
      eoe[p*8 +: 8] = 8'(~d & (~o | (o & ~c & ~l) | (o & c & l)));
      eou[p*8 +: 8] = 8'((~o & l) | (o & c));
      epu[p*8 +: 8] = 8'(m[p][2] & d);
    end
    `CHK(pin_oe, eoe);
    `CHK(pin_out & pin_oe, eou & eoe);
    `CHK(pin_pu, epu);
    `CHK(rst_as_rst, rsm == 0);
    `CHK(key8, rsm ? (lvl(4) >> 3) & 1 : 0);
    `CHK(irq5, rsm ? (lvl(4) >> 3) & 1 : 0);
  endtask
  task automatic do_reset();
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk_sys);
    for (int p = 0; p < 5; p++) m[p] = '{0, 8'hff, p == 4 ? 8 : 0, 0};
    rsm = 0;
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask
  initial begin
    #100000;
    bad_count++;
    finish_test();
  end
  initial begin
    int k, p;
    void'($urandom(32'h09c3));
    ext_val <= 40'({$urandom, $urandom});
    for (int r = 0; r < 2; r++) begin
      do_reset();
      pins_chk();
      for (int kk = 0; kk < 6; kk++) for (int pp = 0; pp < 5; pp++) rd(kk, pp);
      repeat (60) begin
        k = $urandom % 6;
        p = $urandom % 5;
        wr(k, p, $urandom % 256, 1'($urandom), $urandom % 8);
        rd(k, p);
        pins_chk();
        if ($urandom % 4 == 0) begin
          @(posedge clk_sys);
          ext_val <= 40'({$urandom, $urandom});
          repeat (3) @(posedge clk_sys);
        end
      end
    end
    wr(1, 1, 8'hff);
    wr(2, 1, 8'hff);
    ext_en[15:8] <= 8'h00;
    repeat (3) @(posedge clk_sys);
    rd(0, 1);
    wr(1, 1, 8'h00);
    wr(0, 1, 8'ha5);
    pins_chk();
    wr(0, 2, ($urandom % 256) & 8'he7);
    rd(0, 2);
    finish_test();
  end
endmodule
